// ==== core/ssp_defs.svh ====
// Register offsets, field positions and reset values of the serial shift port
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

`define SSP_ADDR_W      8
`define SSP_CTRL_OFS    8'h00
`define SSP_TXBUF_OFS   8'h04
`define SSP_RXBUF_OFS   8'h08
`define SSP_BAUD_OFS    8'h0C
`define SSP_EVENT_OFS   8'h10

`define SSP_WIDTH_MSB   3
`define SSP_WIDTH_LSB   0
`define SSP_MSBF_BIT    4
`define SSP_PHASE_BIT   5
`define SSP_IDLE_BIT    6
`define SSP_ROLE_BIT    14
`define SSP_EN_BIT      15

`define SSP_TXFULL_BIT  0
`define SSP_TXIRQ_BIT   8
`define SSP_RXIRQ_BIT   9
`define SSP_BUSY_BIT    12

`define SSP_EV_TX_BIT   0
`define SSP_EV_RX_BIT   1

`define SSP_WIDTH_RST   4'h7
`define SSP_BAUD_RST    16'h0031

`define SSP_RESP_OKAY   2'h0
`define SSP_RESP_SLVERR 2'h2

`endif

// ==== core/ssp_pkg.sv ====
// Types shared by the serial shift port
package ssp_pkg;
	typedef enum logic [2:0] {
		SSP_IDLE  = 3'b001,
		SSP_START = 3'b010,
		SSP_SHIFT = 3'b100
	} ssp_state_t;
endpackage

// ==== core/ssp_baud_gen.sv ====
// Reloadable 16-bit baud tick generator, one tick per half bit
`timescale 1ns/1ns
`default_nettype none
module ssp_baud_gen (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        run,
	input  wire logic [15:0] reload,
	output logic             tick
);
	import ssp_pkg::*;

	logic [15:0] cnt_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 16'h0000;
			tick  <= 1'b0;
		end else if (!run) begin
			cnt_q <= reload;
			tick  <= 1'b0;
		end else if (cnt_q == 16'h0000) begin
			cnt_q <= reload;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q - 16'h0001;
			tick  <= 1'b0;
		end
	end

	tick_spacing_a: assert property (@(posedge clk) disable iff (!rst_n)
		run && $past(run) && tick |=> !tick || (reload == 16'h0000))
		else $error("baud tick repeated with nonzero reload");
endmodule // ssp_baud_gen
`default_nettype wire

// ==== core/ssp_shift_port.sv ====
// Synchronous serial shift port with AXI4-Lite register access
// Overview of operation
// - Full and half duplex; reload 1 at 33 MHz gives 8.25 MBaud.
// - Master drives the shift clock; slave takes it from outside.
// - Transmit and receive double-buffered; 16-bit baud generator sets clock.
// - Control address shows configuration when disabled, status flags when enabled.
// - Each transfer shifts out and in together, equal bit counts.
// - Transmit word moves into shift register once it is empty.
// - Master starts at once after load; slave waits for shift clock.
// - Transfer start sets busy and the transmit-buffer-free flag.
// - After 2..16 bits, shift register goes to receive buffer, flag raised.
// - No new word at completion clears busy with receive buffer load.
// - Bit order control 0 sends LSB first, 1 sends MSB first.
// - Buffer contents right aligned, word LSB at bit 0.
// - Unused transmit bits ignored; unused receive bits carry nothing valid.
// - One shift clock edge drives data, the opposite edge samples.
// - Phase control picks leading or trailing edge for transmit.
// - Polarity sets idle level; idle high means falling leading edge.
// - Master puts first bit out at next baud tick, only when phase is 0.
// - Slave drives first bit as soon as word enters shift register.
//
// Our own choices: the address map and register access over AXI4-Lite.
`include "ssp_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module ssp_shift_port (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic [`SSP_ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [`SSP_ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	input  wire logic                     shiftClkIn,
	output logic                          shiftClkOut,
	output logic                          shiftClkOe_n,
	input  wire logic                     masterOutLineIn,
	output logic                          masterOutLineOut,
	output logic                          masterOutLineOe_n,
	input  wire logic                     masterInLineIn,
	output logic                          masterInLineOut,
	output logic                          masterInLineOe_n
);
	import ssp_pkg::*;

	// Bus slave state
	logic [`SSP_ADDR_W-1:0] awAddr_q;
	logic                   awHave_q;
	logic [15:0]            wData_q;
	logic [1:0]             wStrb_q;
	logic                   wHave_q;
	logic                   bvalid_q;
	logic [1:0]             bresp_q;
	logic                   rvalid_q;
	logic [1:0]             rresp_q;
	logic [31:0]            rdata_q;

	// Configuration and data registers
	logic        serialEnable_q;
	logic        masterRoleSelect_q;
	logic        clockIdleLevel_q;
	logic        clockPhaseSelect_q;
	logic        msbFirstSelect_q;
	logic [3:0]  widthM1_q;
	logic [15:0] baudReload_q;
	logic [15:0] txWordBuffer_q;
	logic        txFull_q;
	logic [15:0] rxWordBuffer_q;
	logic        transferBusyFlag_q;
	logic        txBufferFreeIrq_q;
	logic        rxWordReadyIrq_q;

	// Engine state
	ssp_state_t  state_q;
	logic [15:0] shift_q;
	logic [4:0]  edgeCnt_q;
	logic        outBit_q;
	logic        clkOut_q;
	logic        clkS1_q;
	logic        clkS2_q;
	logic        clkS3_q;
	logic        motS1_q;
	logic        motS2_q;
	logic        minS1_q;
	logic        minS2_q;
	logic        tick;

	// Write path decode
	wire        wrFire   = awHave_q && wHave_q && !bvalid_q;
	wire        wrCtrl   = wrFire && (awAddr_q == `SSP_CTRL_OFS);
	wire        wrTx     = wrFire && (awAddr_q == `SSP_TXBUF_OFS);
	wire        wrBaud   = wrFire && (awAddr_q == `SSP_BAUD_OFS);
	wire        wrEvent  = wrFire && (awAddr_q == `SSP_EVENT_OFS);
	wire        wrMapped = wrCtrl || wrTx || wrBaud || wrEvent
		|| (awAddr_q == `SSP_RXBUF_OFS);
	wire [15:0] configWord = {serialEnable_q, masterRoleSelect_q, 7'h00, clockIdleLevel_q,
		clockPhaseSelect_q, msbFirstSelect_q, widthM1_q};
	wire [15:0] statusWord = {serialEnable_q, masterRoleSelect_q, 1'b0, transferBusyFlag_q,
		2'h0, rxWordReadyIrq_q, txBufferFreeIrq_q, 7'h00, txFull_q};
	wire [15:0] eventWord  = {14'h0000, rxWordReadyIrq_q, txBufferFreeIrq_q};
	// Byte lanes merged over the register's current content
	wire [15:0] ctrlMerged = {wStrb_q[1] ? wData_q[15:8] : configWord[15:8],
		wStrb_q[0] ? wData_q[7:0] : configWord[7:0]};
	wire [15:0] txMerged   = {wStrb_q[1] ? wData_q[15:8] : txWordBuffer_q[15:8],
		wStrb_q[0] ? wData_q[7:0] : txWordBuffer_q[7:0]};
	wire [15:0] baudMerged = {wStrb_q[1] ? wData_q[15:8] : baudReload_q[15:8],
		wStrb_q[0] ? wData_q[7:0] : baudReload_q[7:0]};
	wire        evClrTx    = wrEvent && wStrb_q[0] && wData_q[`SSP_EV_TX_BIT];
	wire        evClrRx    = wrEvent && wStrb_q[0] && wData_q[`SSP_EV_RX_BIT];
	wire        cfgWrite   = wrCtrl && !serialEnable_q;

	// Read path decode
	wire        arFire  = s_axi_arvalid && !rvalid_q;
	wire [15:0] ctrlView = serialEnable_q ? statusWord : configWord;
	wire        rdCtrl  = (s_axi_araddr == `SSP_CTRL_OFS);
	wire        rdTx    = (s_axi_araddr == `SSP_TXBUF_OFS);
	wire        rdRx    = (s_axi_araddr == `SSP_RXBUF_OFS);
	wire        rdBaud  = (s_axi_araddr == `SSP_BAUD_OFS);
	wire        rdEvent = (s_axi_araddr == `SSP_EVENT_OFS);
	wire        rdHit   = rdCtrl || rdTx || rdRx || rdBaud || rdEvent;
	wire [15:0] rdMux   = rdCtrl ? ctrlView : rdTx ? txWordBuffer_q : rdRx ? rxWordBuffer_q
		: rdBaud ? baudReload_q : rdEvent ? eventWord : 16'h0000;

	assign s_axi_awready = !awHave_q;
	assign s_axi_wready  = !wHave_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			awHave_q <= 1'b0;
			awAddr_q <= 8'h00;
		end else if (s_axi_awvalid && !awHave_q) begin
			awHave_q <= 1'b1;
			awAddr_q <= s_axi_awaddr;
		end else if (wrFire) begin
			awHave_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wHave_q <= 1'b0;
			wData_q <= 16'h0000;
			wStrb_q <= 2'h0;
		end else if (s_axi_wvalid && !wHave_q) begin
			wHave_q <= 1'b1;
			wData_q <= s_axi_wdata[15:0];
			wStrb_q <= s_axi_wstrb[1:0];
		end else if (wrFire) begin
			wHave_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_q <= 1'b0;
			bresp_q  <= `SSP_RESP_OKAY;
		end else if (wrFire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wrMapped ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_q <= 1'b0;
			rresp_q  <= `SSP_RESP_OKAY;
			rdata_q  <= 32'h0000_0000;
		end else if (arFire) begin
			rvalid_q <= 1'b1;
			rresp_q  <= rdHit ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
			rdata_q  <= {16'h0000, rdMux};
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// fields change only while disabled; enable always writable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			serialEnable_q     <= 1'b0;
			masterRoleSelect_q <= 1'b0;
			clockIdleLevel_q   <= 1'b0;
			clockPhaseSelect_q <= 1'b0;
			msbFirstSelect_q   <= 1'b0;
			widthM1_q          <= `SSP_WIDTH_RST;
		end else begin
			if (wrCtrl)
				serialEnable_q <= ctrlMerged[`SSP_EN_BIT];
			if (cfgWrite) begin
				masterRoleSelect_q <= ctrlMerged[`SSP_ROLE_BIT];
				clockIdleLevel_q   <= ctrlMerged[`SSP_IDLE_BIT];
				clockPhaseSelect_q <= ctrlMerged[`SSP_PHASE_BIT];
				msbFirstSelect_q   <= ctrlMerged[`SSP_MSBF_BIT];
				// A one-bit word is not legal; the shortest is two
				widthM1_q <= (ctrlMerged[`SSP_WIDTH_MSB:`SSP_WIDTH_LSB] == 4'h0) ? 4'h1
					: ctrlMerged[`SSP_WIDTH_MSB:`SSP_WIDTH_LSB];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			baudReload_q <= `SSP_BAUD_RST;
		else if (wrBaud && !serialEnable_q)
			baudReload_q <= baudMerged;
	end

	// Input synchronisers; first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clkS1_q <= 1'b0;
			clkS2_q <= 1'b0;
			clkS3_q <= 1'b0;
			motS1_q <= 1'b1;
			motS2_q <= 1'b1;
			minS1_q <= 1'b1;
			minS2_q <= 1'b1;
		end else begin
			clkS1_q <= shiftClkIn;
			clkS2_q <= clkS1_q;
			clkS3_q <= clkS2_q;
			motS1_q <= masterOutLineIn;
			motS2_q <= motS1_q;
			minS1_q <= masterInLineIn;
			minS2_q <= minS1_q;
		end
	end

	// baud generator runs only for an enabled master
	ssp_baud_gen u_baud (
		.clk    (clk),
		.rst_n  (rst_n),
		.run    (serialEnable_q && masterRoleSelect_q),
		.reload (baudReload_q),
		.tick   (tick)
	);

	// Per-bit width mask and receive shift-in paths
	logic [15:0] widthMask;
	logic [15:0] shInLsb;
	logic [15:0] shInMsb;
	wire         rxBit = masterRoleSelect_q ? minS2_q : motS2_q;
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_bit
			localparam logic [3:0] IDX = 4'(gi);
			assign widthMask[gi] = (IDX <= widthM1_q);
			// LSB first enters at the top of the word and moves down
			if (gi < 15) begin : g_lo
				assign shInLsb[gi] = (IDX == widthM1_q) ? rxBit
					: (IDX < widthM1_q) ? shift_q[gi+1] : 1'b0;
			end else begin : g_top
				assign shInLsb[gi] = (IDX == widthM1_q) ? rxBit : 1'b0;
			end
			// MSB first enters at bit 0 and moves up
			if (gi == 0) begin : g_first
				assign shInMsb[gi] = rxBit;
			end else begin : g_up
				assign shInMsb[gi] = (IDX <= widthM1_q) ? shift_q[gi-1] : 1'b0;
			end
		end
	endgenerate

	// Engine decode
	wire        slaveEdge  = (clkS2_q != clkS3_q);
	wire        inShift    = (state_q == SSP_SHIFT);
	// master paced by own ticks, slave by the external clock
	wire        edgeNow    = inShift && (masterRoleSelect_q ? tick : slaveEdge);
	wire        startTick  = (state_q == SSP_START) && tick;
	wire        lastEdge   = (edgeCnt_q == {widthM1_q, 1'b1});
	// even edges lead; phase 0 samples on leading edges
	wire        sampleEdge = (edgeCnt_q[0] == clockPhaseSelect_q);
	wire        doneNow    = edgeNow && lastEdge;
	// load once the shift register is empty or just emptied
	wire        loadNow    = serialEnable_q && txFull_q && ((state_q == SSP_IDLE) || doneNow);
	wire [15:0] shNext     = msbFirstSelect_q ? shInMsb : shInLsb;
	wire [15:0] txMasked   = txWordBuffer_q & widthMask;
	wire        selShift   = msbFirstSelect_q ? shift_q[widthM1_q] : shift_q[0];
	wire        selLoad    = msbFirstSelect_q ? txMasked[widthM1_q] : txMasked[0];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			state_q <= SSP_IDLE;
		else if (!serialEnable_q)
			state_q <= SSP_IDLE;
		// master waits one tick, slave goes straight to shifting
		else if (loadNow)
			state_q <= masterRoleSelect_q ? SSP_START : SSP_SHIFT;
		else if (startTick)
			state_q <= SSP_SHIFT;
		else if (doneNow)
			state_q <= SSP_IDLE;
	end

	// every edge pair moves one bit out and one in
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_q   <= 16'h0000;
			edgeCnt_q <= 5'h00;
		end else if (loadNow) begin
			// bits above the width never reach the line
			shift_q   <= txMasked;
			edgeCnt_q <= 5'h00;
		end else if (edgeNow) begin
			edgeCnt_q <= edgeCnt_q + 5'h01;
			if (sampleEdge)
				shift_q <= shNext;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			outBit_q <= 1'b1;
		else if (!serialEnable_q)
			outBit_q <= 1'b1;
		// slave presents first bit on load
		else if (loadNow && !masterRoleSelect_q)
			outBit_q <= selLoad;
		// master presents first bit at the next tick when phase is 0
		else if (startTick && !clockPhaseSelect_q)
			outBit_q <= selShift;
		// Line keeps the last bit after the final edge
		else if (edgeNow && !sampleEdge && !lastEdge)
			outBit_q <= selShift;
	end

	// Follows a polarity write in the same cycle, so the line never lags the setting
	wire        idleNext   = cfgWrite ? ctrlMerged[`SSP_IDLE_BIT] : clockIdleLevel_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			clkOut_q <= 1'b0;
		else if (!serialEnable_q || !masterRoleSelect_q || (state_q != SSP_SHIFT))
			clkOut_q <= idleNext;
		else if (edgeNow)
			clkOut_q <= !clkOut_q;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			txWordBuffer_q <= 16'h0000;
			txFull_q       <= 1'b0;
		end else if (wrTx) begin
			// A write in the load cycle refills the buffer
			txWordBuffer_q <= txMerged;
			txFull_q       <= 1'b1;
		end else if (loadNow) begin
			txFull_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rxWordBuffer_q <= 16'h0000;
		else if (doneNow)
			rxWordBuffer_q <= (sampleEdge ? shNext : shift_q) & widthMask;
	end

	// busy has no software write path
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			transferBusyFlag_q <= 1'b0;
		else if (!serialEnable_q)
			transferBusyFlag_q <= 1'b0;
		else if (loadNow)
			transferBusyFlag_q <= 1'b1;
		// busy drops with the receive load
		else if (doneNow)
			transferBusyFlag_q <= 1'b0;
	end

	// event flags, a set beats a same-cycle clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			txBufferFreeIrq_q <= 1'b0;
			rxWordReadyIrq_q  <= 1'b0;
		end else begin
			if (loadNow)
				txBufferFreeIrq_q <= 1'b1;
			else if (evClrTx)
				txBufferFreeIrq_q <= 1'b0;
			if (doneNow)
				rxWordReadyIrq_q <= 1'b1;
			else if (evClrRx)
				rxWordReadyIrq_q <= 1'b0;
		end
	end

	// separate in and out lines allow full duplex
	// pin roles follow the role bit
	assign shiftClkOut       = clkOut_q;
	assign shiftClkOe_n      = !masterRoleSelect_q;
	assign masterOutLineOut  = outBit_q;
	assign masterOutLineOe_n = !masterRoleSelect_q;
	assign masterInLineOut   = outBit_q;
	assign masterInLineOe_n  = masterRoleSelect_q;

	busy_on_start_a: assert property (@(posedge clk) disable iff (!rst_n)
		loadNow |=> transferBusyFlag_q && txBufferFreeIrq_q)
		else $error("busy or tx flag not set at start");
	rx_on_done_a: assert property (@(posedge clk) disable iff (!rst_n)
		doneNow |=> rxWordReadyIrq_q && (state_q != SSP_START || masterRoleSelect_q))
		else $error("rx flag missing after transfer");
	busy_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		doneNow && !txFull_q && !wrTx |=> !transferBusyFlag_q && (state_q == SSP_IDLE))
		else $error("busy not cleared at completion");
	idle_pins_a: assert property (@(posedge clk) disable iff (!rst_n)
		!serialEnable_q && $past(!serialEnable_q) |-> outBit_q && (clkOut_q == clockIdleLevel_q))
		else $error("pins not idle while disabled");
	config_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
		serialEnable_q |=> $stable(widthM1_q) && $stable(baudReload_q) && $stable(clockPhaseSelect_q))
		else $error("configuration changed while enabled");
	slave_first_a: assert property (@(posedge clk) disable iff (!rst_n)
		loadNow && !masterRoleSelect_q |=> outBit_q == $past(selLoad))
		else $error("slave first bit not driven on load");
	master_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
		loadNow && masterRoleSelect_q |=> (state_q == SSP_START) && (clkOut_q == clockIdleLevel_q))
		else $error("master started without waiting for tick");
	edge_count_a: assert property (@(posedge clk) disable iff (!rst_n)
		doneNow |-> edgeCnt_q == {widthM1_q, 1'b1} && clkOut_q != clockIdleLevel_q
		|| !masterRoleSelect_q)
		else $error("transfer ended on wrong edge count");
	write_resp_a: assert property (@(posedge clk) disable iff (!rst_n)
		wrFire |=> bvalid_q ##0 !awHave_q && !wHave_q)
		else $error("write not answered");
endmodule // ssp_shift_port
`default_nettype wire

// ==== test/ssp_peer_model.sv ====
// Far-side serial peer: answers as slave or makes the shift clock as master
`timescale 1ns/1ns
`default_nettype none
module ssp_peer_model (
	input  wire logic sclkLine,
	input  wire logic dataIn,
	output logic      sclkOut,
	output logic      dataOut
);
	localparam int HALF_NS = 60;
	logic [15:0] rxWord;
	logic        lastBit;

	initial begin
		sclkOut = 1'b0;
		dataOut = 1'b1;
		lastBit = 1'b1;
		rxWord  = 16'h0000;
	end

	function automatic int pos(input logic msbf, input int w, input int k);
		return msbf ? w - 1 - k : k;
	endfunction

	// Clock line parked at idle so enabling sees no stray edge
	task automatic park(input logic idle);
		sclkOut = idle;
	endtask

	// clock only when the design listens
	task automatic exchange(input logic makeClk, idle, ph, msbf, input int w,
			input logic [15:0] tx);
		int e;
		rxWord = 16'h0000;
		sclkOut = idle;
		// first bit valid before a leading-edge sample
		if (!ph) dataOut = tx[pos(msbf, w, 0)];
		if (makeClk) #(HALF_NS);
		for (e = 0; e < 2 * w; e++) begin
			if (makeClk) #(HALF_NS) sclkOut = ~sclkOut;
			else @(sclkLine);
			if ((e % 2 == 0) == !ph) rxWord[pos(msbf, w, e / 2)] = dataIn;
			else if (ph || e / 2 + 1 < w) dataOut = tx[pos(msbf, w, ph ? e / 2 : e / 2 + 1)];
		end
		lastBit = dataOut;
		// Released line must not keep showing the last bit
		#(makeClk ? HALF_NS : 20) dataOut = ~lastBit;
	endtask
endmodule // ssp_peer_model
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the serial shift port
`include "ssp_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic        clk;
	logic        rst_n;
	logic [7:0]  s_axi_awaddr;
	logic        s_axi_awvalid;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_wvalid;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready;
	logic [7:0]  s_axi_araddr;
	logic        s_axi_arvalid;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready;
	logic        shiftClkOut, shiftClkOe_n;
	logic        masterOutLineOut, masterOutLineOe_n;
	logic        masterInLineOut, masterInLineOe_n;
	logic        sclkLine, mosiLine, misoLine, peerIn, peerClk, peerData;
	logic [31:0] rd;
	logic [1:0]  rs;
	int          mismatches;
	int          totalChecks;

	// Each wire resolved from whoever has its driver on
	assign sclkLine = shiftClkOe_n ? peerClk : shiftClkOut;
	assign mosiLine = masterOutLineOe_n ? peerData : masterOutLineOut;
	assign misoLine = masterInLineOe_n ? peerData : masterInLineOut;
	assign peerIn   = shiftClkOe_n ? misoLine : mosiLine;

	ssp_shift_port i_ssp_shift_port (
		.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .shiftClkIn(sclkLine),
		.shiftClkOut, .shiftClkOe_n, .masterOutLineIn(mosiLine), .masterOutLineOut,
		.masterOutLineOe_n, .masterInLineIn(misoLine), .masterInLineOut, .masterInLineOe_n
	);
	ssp_peer_model i_ssp_peer_model (
		.sclkLine(sclkLine), .dataIn(peerIn), .sclkOut(peerClk), .dataOut(peerData)
	);

	task automatic check(input logic [31:0] seen, exp);
		totalChecks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// Ready is sampled half a cycle ahead; it only moves on rising edges
	task automatic axiWrite(input logic [7:0] a, input logic [15:0] d);
		logic aw, w, b;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge clk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge clk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end while (!b);
		s_axi_bready <= 1'b0;
	endtask

	task automatic axiRead(input logic [7:0] a);
		logic ar, r;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge clk);
			ar = s_axi_arvalid && s_axi_arready;
			r = s_axi_rvalid;
			rd = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge clk);
			if (ar) s_axi_arvalid <= 1'b0;
		end while (!r);
		s_axi_rready <= 1'b0;
	endtask

	task automatic resetValues();
		check({30'h0, shiftClkOut, masterOutLineOut}, {30'h0, 2'b01});
		axiRead(`SSP_CTRL_OFS);
		check(rd, {28'h0, `SSP_WIDTH_RST});
		axiRead(`SSP_BAUD_OFS);
		check(rd, {16'h0, `SSP_BAUD_RST});
		axiRead(8'h14);
		check(rd, 32'h0);
		check({30'h0, rs}, {30'h0, `SSP_RESP_SLVERR});
		axiWrite(8'h14, 16'h00FF);
		check({30'h0, rs}, {30'h0, `SSP_RESP_SLVERR});
	endtask

	task automatic finishXfer(input logic role);
		axiRead(`SSP_CTRL_OFS);
		check(rd, {16'h0, 1'b1, role, 4'h0, 2'h3, 8'h00});
		axiRead(`SSP_EVENT_OFS);
		check(rd, 32'h3);
		axiWrite(`SSP_EVENT_OFS, 16'h0003);
		axiWrite(`SSP_CTRL_OFS, 16'h0000);
	endtask

	task automatic runXfer(input logic role, idle, ph, msbf, input int w,
			input logic [15:0] txD, txP);
		logic [15:0] cfg;
		logic [15:0] m;
		cfg = {1'b0, role, 7'h00, idle, ph, msbf, 4'(w - 1)};
		m = 16'((32'h1 << w) - 32'h1);
		axiWrite(`SSP_CTRL_OFS, cfg);
		i_ssp_peer_model.park(idle);
		repeat (3) @(posedge clk);
		check({30'h0, shiftClkOut, masterOutLineOut}, {30'h0, idle, 1'b1});
		fork
			begin
				if (!role) repeat (16) @(posedge clk);
				i_ssp_peer_model.exchange(!role, idle, ph, msbf, w, txP);
			end
			begin
				axiWrite(`SSP_TXBUF_OFS, txD);
				axiWrite(`SSP_CTRL_OFS, cfg | 16'h8000);
				if (role) begin
					axiRead(`SSP_CTRL_OFS);
					check(rd & 32'h9000, 32'h9000);
				end
			end
		join
		repeat (6) @(posedge clk);
		axiRead(`SSP_RXBUF_OFS);
		check(rd, {16'h0, txP & m});
		check({16'h0, i_ssp_peer_model.rxWord}, {16'h0, txD & m});
		finishXfer(role);
	endtask

	task automatic masterModes();
		axiWrite(`SSP_BAUD_OFS, 16'h0007);
		runXfer(1'b1, 1'b0, 1'b0, 1'b1, 8, 16'hFFA5, 16'h003C);
		runXfer(1'b1, 1'b0, 1'b1, 1'b0, 2, 16'hFFFE, 16'h0001);
		runXfer(1'b1, 1'b1, 1'b0, 1'b0, 16, 16'h8E71, 16'h5AC3);
		runXfer(1'b1, 1'b1, 1'b1, 1'b1, 5, 16'h0013, 16'h000A);
	endtask

	task automatic slaveModes();
		runXfer(1'b0, 1'b0, 1'b0, 1'b1, 8, 16'h00B4, 16'h00E1);
		runXfer(1'b0, 1'b1, 1'b1, 1'b0, 12, 16'hF6D9, 16'h0A5F);
	endtask

	task automatic backToBack();
		logic [15:0] firstRx;
		axiWrite(`SSP_CTRL_OFS, 16'h4017);
		i_ssp_peer_model.park(1'b0);
		fork
			begin
				i_ssp_peer_model.exchange(1'b0, 1'b0, 1'b0, 1'b1, 8, 16'h0096);
				firstRx = i_ssp_peer_model.rxWord;
				i_ssp_peer_model.exchange(1'b0, 1'b0, 1'b0, 1'b1, 8, 16'h0069);
			end
			begin
				axiWrite(`SSP_TXBUF_OFS, 16'h00C3);
				axiWrite(`SSP_CTRL_OFS, 16'hC017);
				axiWrite(`SSP_TXBUF_OFS, 16'h005A);
				axiRead(`SSP_CTRL_OFS);
				check(rd & 32'h1001, 32'h1001);
			end
		join
		repeat (6) @(posedge clk);
		axiRead(`SSP_RXBUF_OFS);
		check(rd, 32'h69);
		check({16'h0, firstRx}, 32'hC3);
		check({16'h0, i_ssp_peer_model.rxWord}, 32'h5A);
		finishXfer(1'b1);
	endtask

	task automatic configLock();
		axiWrite(`SSP_CTRL_OFS, 16'h0027);
		axiRead(`SSP_CTRL_OFS);
		check(rd, 32'h27);
		axiWrite(`SSP_CTRL_OFS, 16'h8027);
		axiRead(`SSP_CTRL_OFS);
		check(rd, 32'h8000);
		axiWrite(`SSP_BAUD_OFS, 16'h1234);
		axiWrite(`SSP_CTRL_OFS, 16'h803F);
		axiWrite(`SSP_CTRL_OFS, 16'h0000);
		axiRead(`SSP_CTRL_OFS);
		check(rd, 32'h27);
		axiRead(`SSP_BAUD_OFS);
		check(rd, 32'h7);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", totalChecks, mismatches);
		if (mismatches == 0 && totalChecks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		{rst_n, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		mismatches = 0;
		totalChecks = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		resetValues();
		masterModes();
		backToBack();
		slaveModes();
		configLock();
		summarize();
	end

	// Whole run needs roughly 15 us; a hang ends at 300 us, far later than this
	initial begin
		#300000;
		mismatches++;
		summarize();
	end
endmodule // testbench
`default_nettype wire
